// file: hdl/irq_arbiter_defines.svh
`ifndef IRQ_ARBITER_DEFINES_SVH
`define IRQ_ARBITER_DEFINES_SVH

// Register addresses and reset values
`define IRQ_ENABLE_ADDR     8'ha8
`define IRQ_PRIO_ADDR       8'hb8
`define IRQ_EXT_EN_ADDR     8'he6
`define IRQ_EXT_PRIO_ADDR   8'hf6
`define IRQ_ENABLE_RST      8'h00
`define IRQ_PRIO_RST        8'h00
`define IRQ_EXT_RST         8'h00
`define IRQ_PRIO_RD_ONES    8'h80
`define IRQ_EXT_WMASK       8'hbd

// Enable register fields
`define IRQ_GATE_BIT        7
`define IRQ_SPI_BIT         6
`define IRQ_TMR_C_BIT       5
`define IRQ_UART_BIT        4
`define IRQ_TMR_B_BIT       3
`define IRQ_EXT_B_BIT       2
`define IRQ_TMR_A_BIT       1
`define IRQ_EXT_A_BIT       0

// Source map
`define IRQ_NSRC            15
`define IRQ_PRIMARY_SRC     7
`define IRQ_RSVD_MASK       15'h2100
`define IRQ_HELD_SRC        4
`define IRQ_SPI_ORDER       6
`define IRQ_TMR_C_ORDER     5

// Vectors and timing
`define IRQ_VEC_BASE        16'h0003
`define IRQ_DETECT_CYCLES   1
`define IRQ_CALL_CYCLES     4

`endif

// file: hdl/irq_arbiter_pkg.sv
package irq_arbiter_pkg;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_wr_t;

   typedef struct packed {
      logic vector_taken;
      logic return_from_irq;
      logic instr_done;
   } core_status_t;

   typedef struct packed {
      logic        valid;
      logic        high;
      logic [15:0] vector;
   } irq_req_t;

endpackage

// file: hdl/two_level_interrupt_arbiter.sv

`include "irq_arbiter_defines.svh"

`timescale 1ns/1ps
`default_nettype none

module two_level_interrupt_arbiter (
   input  wire logic                         sys_clk,
   input  wire logic                         rst_n,
   input  wire irq_arbiter_pkg::sfr_wr_t     sfr_wr,
   input  wire logic [7:0]                   sfr_rd_addr,
   output logic [7:0]                        sfr_rd_data,
   input  wire logic                         ext_in_a,
   input  wire logic                         ext_in_b,
   input  wire logic                         timer_a_overflow,
   input  wire logic                         timer_b_overflow,
   input  wire logic [3:0]                   flag_sw_set,
   input  wire logic [3:0]                   flag_sw_clr,
   output logic [3:0]                        held_flags,
   input  wire logic                         timer_c_low_overflow,
   input  wire logic                         timer_c_high_overflow,
   input  wire logic [3:0]                   spi_flags,
   input  wire logic [14:0]                  periph_pending,
   input  wire irq_arbiter_pkg::core_status_t core_status,
   output irq_arbiter_pkg::irq_req_t         irq_req,
   output logic [1:0]                        active_levels
);

   import irq_arbiter_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************

   logic [7:0]                irq_enable_mask;
   logic [7:0]                priority_select_primary;
   logic [7:0]                enable_mask_extended;
   logic [7:0]                priority_select_extended;

   logic [1:0]                ext_a_sync;
   logic [1:0]                ext_b_sync;
   logic                      ext_a_last;
   logic                      ext_b_last;
   logic                      ext_a_fall;
   logic                      ext_b_fall;

   logic [3:0]                held_set;
   logic [3:0]                held_hw_clr;
   logic [3:0]                next_held;

   logic [`IRQ_NSRC-1:0]      src_flag;
   logic [`IRQ_NSRC-1:0]      src_en;
   logic [`IRQ_NSRC-1:0]      src_prio;
   logic [`IRQ_NSRC-1:0]      req_high;
   logic [`IRQ_NSRC-1:0]      req_low;

   logic [3:0]                win_order;
   logic                      win_valid;
   logic                      win_high;
   logic                      eligible;

   logic                      global_irq_gate;
   logic                      in_high;
   logic                      in_low;
   logic                      hold_after_return;
   logic [3:0]                taken_order;

   irq_req_t                  next_req;

   logic                      wr_enable;
   logic                      wr_prio;
   logic                      wr_ext_en;
   logic                      wr_ext_prio;
   logic [`IRQ_NSRC-1:0]      src_rsvd;

   // ************************************************************
   // Register write decode
   // ************************************************************

   assign wr_enable   = sfr_wr.wr && sfr_wr.addr == `IRQ_ENABLE_ADDR;
   assign wr_prio     = sfr_wr.wr && sfr_wr.addr == `IRQ_PRIO_ADDR;
   assign wr_ext_en   = sfr_wr.wr && sfr_wr.addr == `IRQ_EXT_EN_ADDR;
   assign wr_ext_prio = sfr_wr.wr && sfr_wr.addr == `IRQ_EXT_PRIO_ADDR;

   // ************************************************************
   // Enable and priority registers
   // ************************************************************

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable_mask <= `IRQ_ENABLE_RST;
      end else if (wr_enable) begin
         irq_enable_mask <= sfr_wr.wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         priority_select_primary <= `IRQ_PRIO_RST;
      end else if (wr_prio) begin
         priority_select_primary <= sfr_wr.wdata & ~`IRQ_PRIO_RD_ONES;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_mask_extended <= `IRQ_EXT_RST;
      end else if (wr_ext_en) begin
         enable_mask_extended <= sfr_wr.wdata & `IRQ_EXT_WMASK;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         priority_select_extended <= `IRQ_EXT_RST;
      end else if (wr_ext_prio) begin
         priority_select_extended <= sfr_wr.wdata & `IRQ_EXT_WMASK;
      end
   end

   // Read data registered one cycle after the address
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rd_data <= 8'h00;
      end else begin
         case (sfr_rd_addr)
            `IRQ_ENABLE_ADDR: begin
               sfr_rd_data <= irq_enable_mask;
            end
            `IRQ_PRIO_ADDR: begin
               sfr_rd_data <= priority_select_primary | `IRQ_PRIO_RD_ONES;
            end
            `IRQ_EXT_EN_ADDR: begin
               sfr_rd_data <= enable_mask_extended;
            end
            `IRQ_EXT_PRIO_ADDR: begin
               sfr_rd_data <= priority_select_extended;
            end
            // Unmapped addresses read zero
            default: begin
               sfr_rd_data <= 8'h00;
            end
         endcase
      end
   end

   // ************************************************************
   // External input synchronisers and edge detect
   // ************************************************************

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         // Idle high, so release gives no false edge
         ext_a_sync <= 2'h3;
         ext_b_sync <= 2'h3;
         ext_a_last <= 1'b1;
         ext_b_last <= 1'b1;
      end else begin
         ext_a_sync <= {ext_a_sync[0], ext_in_a};
         ext_b_sync <= {ext_b_sync[0], ext_in_b};
         ext_a_last <= ext_a_sync[1];
         ext_b_last <= ext_b_sync[1];
      end
   end

   // Inputs are active low, edge sensitive
   assign ext_a_fall = ext_a_last & ~ext_a_sync[1];
   assign ext_b_fall = ext_b_last & ~ext_b_sync[1];

   // ************************************************************
   // Pending flags held here (orders 0 to 3)
   // ************************************************************

   // Flags rise on the event whatever the enables say
   assign held_set = {timer_b_overflow, ext_b_fall,
                      timer_a_overflow, ext_a_fall} | flag_sw_set;

   // Cleared when the core takes the vector of that source
   always_comb begin
      held_hw_clr = 4'h0;
      if (core_status.vector_taken && taken_order < 4'(`IRQ_HELD_SRC)) begin
         held_hw_clr[taken_order[1:0]] = 1'b1;
      end
   end

   // A set in the same cycle as a clear wins
   assign next_held = (held_flags & ~held_hw_clr & ~flag_sw_clr) | held_set;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         held_flags <= 4'h0;
      end else begin
         held_flags <= next_held;
      end
   end

   // ************************************************************
   // Per-source flag, enable and priority
   // ************************************************************

   assign global_irq_gate = irq_enable_mask[`IRQ_GATE_BIT];

   always_comb begin
      src_flag = periph_pending;
      src_flag[`IRQ_HELD_SRC-1:0] = held_flags;
      src_flag[`IRQ_TMR_C_ORDER] = timer_c_low_overflow
                                   | timer_c_high_overflow;
      src_flag[`IRQ_SPI_ORDER] = |spi_flags;
   end

   // Reserved orders never request
   assign src_rsvd = `IRQ_RSVD_MASK;

   // Primary bits map to orders 0..6, extended bit k to order k+7;
   // this covers the UART, timer and external gates as one map
   genvar gi;
   generate
      for (gi = 0; gi < `IRQ_NSRC; gi++) begin : g_src
         if (gi < `IRQ_PRIMARY_SRC) begin : g_pri
            assign src_en[gi]   = irq_enable_mask[gi];
            assign src_prio[gi] = priority_select_primary[gi];
         end else begin : g_ext
            assign src_en[gi]   = enable_mask_extended[gi-`IRQ_PRIMARY_SRC];
            assign src_prio[gi] = priority_select_extended[gi-`IRQ_PRIMARY_SRC];
         end
         assign req_high[gi] = src_flag[gi] & src_en[gi] & global_irq_gate
                               & ~src_rsvd[gi] & src_prio[gi];
         assign req_low[gi]  = src_flag[gi] & src_en[gi] & global_irq_gate
                               & ~src_rsvd[gi] & ~src_prio[gi];
      end
   endgenerate

   // ************************************************************
   // Arbitration, evaluated every cycle
   // ************************************************************

   always_comb begin
      win_order = 4'h0;
      win_valid = 1'b0;
      win_high  = 1'b0;
      // Lowest order wins inside a level, high level first
      for (int i = `IRQ_NSRC - 1; i >= 0; i--) begin
         if (req_low[i]) begin
            win_order = 4'(i);
            win_valid = 1'b1;
         end
      end
      for (int i = `IRQ_NSRC - 1; i >= 0; i--) begin
         if (req_high[i]) begin
            win_order = 4'(i);
            win_valid = 1'b1;
            win_high  = 1'b1;
         end
      end
   end

   // Nesting: only high may enter over low, nothing over high
   always_comb begin
      eligible = 1'b0;
      if (win_valid && !in_high && !hold_after_return) begin
         eligible = !in_low || win_high;
      end
   end

   always_comb begin
      next_req        = '0;
      next_req.valid  = eligible && !core_status.vector_taken
                        && !core_status.return_from_irq;
      next_req.high   = win_high;
      next_req.vector = `IRQ_VEC_BASE + {9'h000, win_order, 3'h0};
   end

   // One detect cycle, then the core spends the call cycles
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_req     <= '0;
         taken_order <= 4'h0;
      end else begin
         irq_req     <= next_req;
         // Order of the standing request, for the flag clear on the call
         taken_order <= win_order;
      end
   end

   // ************************************************************
   // Service level tracking
   // ************************************************************

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_high <= 1'b0;
         in_low  <= 1'b0;
      end else if (core_status.return_from_irq) begin
         // A return in the cycle of a call wins
         if (in_high) begin
            in_high <= 1'b0;
         end else begin
            in_low <= 1'b0;
         end
      end else if (core_status.vector_taken && irq_req.valid) begin
         if (irq_req.high) begin
            in_high <= 1'b1;
         end else begin
            in_low <= 1'b1;
         end
      end
   end

   // After a return, wait for the next instruction to finish
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_after_return <= 1'b0;
      end else if (core_status.return_from_irq) begin
         hold_after_return <= 1'b1;
      end else if (core_status.instr_done) begin
         hold_after_return <= 1'b0;
      end
   end

   assign active_levels = {in_high, in_low};

endmodule

`default_nettype wire

// file: tb/irq_props.sv
`timescale 1ns/1ps
`default_nettype none
module irq_props import irq_arbiter_pkg::*; (
   input wire logic                          sys_clk,
   input wire logic                          rst_n,
   input wire logic                          timer_a_overflow,
   input wire logic                          timer_b_overflow,
   input wire logic [3:0]                    flag_sw_set,
   input wire logic [3:0]                    held_flags,
   input wire irq_arbiter_pkg::core_status_t core_status,
   input wire irq_arbiter_pkg::irq_req_t     irq_req,
   input wire logic [1:0]                    active_levels
);
   // ************************
   // Arbiter checks
   // ************************
   logic [3:0] held_d;
   logic [1:0] ord_d;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         held_d <= 4'h0;
         ord_d  <= 2'h0;
      end else begin
         held_d <= held_flags;
         ord_d  <= irq_req.vector[4:3];
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   chk_high_no_req: assert property (active_levels[1] |-> !irq_req.valid)
      else $error("request inside high routine");
   chk_vector_form: assert property (irq_req.valid |->
      irq_req.vector[2:0] == 3'h3 && irq_req.vector[15:7] == 9'h0 &&
      irq_req.vector[6:3] != 4'h8 && irq_req.vector[6:3] != 4'hd)
      else $error("bad vector");
   chk_low_waits: assert property (active_levels == 2'b01 && irq_req.valid |-> irq_req.high)
      else $error("low request inside low routine");
   chk_taken_drop: assert property (core_status.vector_taken |=> !irq_req.valid)
      else $error("request stands after call");
   chk_ret_block: assert property (core_status.return_from_irq |=> !irq_req.valid)
      else $error("request right after return");
   chk_ret_level: assert property (core_status.return_from_irq |=>
      active_levels == ($past(active_levels[1]) ? {1'b0, $past(active_levels[0])} : 2'b00))
      else $error("return left wrong level");
   chk_flag_clear: assert property (core_status.vector_taken &&
      !core_status.return_from_irq && irq_req.vector[15:5] == 11'h0 && flag_sw_set == 4'h0 &&
      !timer_a_overflow && !timer_b_overflow |=> held_flags[ord_d] == 1'b0)
      else $error("flag kept after call");
   chk_flag_req: assert property (irq_req.valid && irq_req.vector[15:5] == 11'h0 |->
      held_d[irq_req.vector[4:3]])
      else $error("request without flag");
endmodule
bind two_level_interrupt_arbiter irq_props chk (.sys_clk, .rst_n, .timer_a_overflow,
   .timer_b_overflow, .flag_sw_set, .held_flags, .core_status, .irq_req, .active_levels);
`default_nettype wire

// file: tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model import irq_arbiter_pkg::*; (
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   input  wire irq_arbiter_pkg::irq_req_t  irq_req,
   input  wire logic [2:0]                 delay,
   input  wire logic                       ret,
   output irq_arbiter_pkg::core_status_t   core_status
);
   // ************************
   // Core side of the vector handshake
   // ************************
   logic [3:0] wait_cnt;
   logic [3:0] instr_cnt;
   logic       busy;
   assign busy = ret || instr_cnt != 4'h0;
   // Accept after delay cycles, never while a return is in flight
   assign core_status.vector_taken = irq_req.valid && !busy && wait_cnt == {1'b0, delay};
   assign core_status.return_from_irq = ret;
   // One instruction follows a return, up to eight cycles long
   assign core_status.instr_done = instr_cnt == 4'h1;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) wait_cnt <= 4'h0;
      else if (!irq_req.valid || core_status.vector_taken) wait_cnt <= 4'h0;
      else if (wait_cnt != {1'b0, delay}) wait_cnt <= wait_cnt + 4'h1;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) instr_cnt <= 4'h0;
      else if (ret) instr_cnt <= {1'b0, delay} + 4'h1;
      else if (instr_cnt != 4'h0) instr_cnt <= instr_cnt - 4'h1;
   end
endmodule
`default_nettype wire

// file: tb/two_level_interrupt_arbiter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module two_level_interrupt_arbiter_tb;
   import irq_arbiter_pkg::*;
   // ************************
   // Bench
   // ************************
   logic         sys_clk, rst_n, ext_in_a, ext_in_b, timer_a_overflow, timer_b_overflow;
   logic         timer_c_low_overflow, timer_c_high_overflow, ret, rd_v;
   logic         rd_seen = 1'b0;
   logic [3:0]   flag_sw_set, flag_sw_clr, held_flags, spi_flags;
   logic [7:0]   sfr_rd_addr, sfr_rd_data;
   logic [14:0]  periph_pending;
   logic [1:0]   active_levels;
   logic [2:0]   delay;
   sfr_wr_t      sfr_wr;
   core_status_t core_status;
   irq_req_t     irq_req;
   logic [15:0]  vq[$];
   logic [7:0]   rq[$];
   logic [15:0]  seq[4] = '{16'h001b, 16'h0003, 16'h000b, 16'h0013};
   int           mismatches = 0, comparisons = 0, ntaken = 0, want = 0, seed, k;

   two_level_interrupt_arbiter dut (.sys_clk, .rst_n, .sfr_wr, .sfr_rd_addr, .sfr_rd_data,
      .ext_in_a, .ext_in_b, .timer_a_overflow, .timer_b_overflow, .flag_sw_set, .flag_sw_clr,
      .held_flags, .timer_c_low_overflow, .timer_c_high_overflow, .spi_flags, .periph_pending,
      .core_status, .irq_req, .active_levels);
   core_model core (.sys_clk, .rst_n, .irq_req, .delay, .ret, .core_status);

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task conclude;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task step;
      @(posedge sys_clk);
      #1;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      sfr_wr = {1'b1, a, d};
      rd_v = 1'b0;
      step();
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      rq.push_back(e);
      sfr_wr.wr = 1'b0;
      sfr_rd_addr = a;
      rd_v = 1'b1;
      step();
   endtask
   task idle;
      sfr_wr.wr = 1'b0;
      rd_v = 1'b0;
      step();
   endtask
   task expect_vec(input logic [15:0] v);
      vq.push_back(v);
      want++;
   endtask
   task automatic take;
      int n = 0;
      while (ntaken < want && n < 300) begin
         step();
         n++;
      end
      if (ntaken < want) begin
         check("vector calls", 16'(want), 16'(ntaken));
         conclude();
      end
   endtask
   task ret_irq;
      ret = 1'b1;
      step();
      ret = 1'b0;
      repeat (12) step();
   endtask
   // Results are matched against the oldest note
   always @(posedge sys_clk) begin
      if (rd_seen) check("read data", {8'h00, rq.pop_front()}, {8'h00, sfr_rd_data});
      rd_seen <= rd_v;
      if (core_status.vector_taken === 1'b1) begin
         ntaken++;
         check("vector", vq.size() > 0 ? vq.pop_front() : 16'hffff, irq_req.vector);
      end
   end
   initial begin
      seed = 32'hf6d84f23;
      {rst_n, ext_in_a, ext_in_b, timer_a_overflow, timer_b_overflow, ret, rd_v} = 7'h30;
      {timer_c_low_overflow, timer_c_high_overflow, flag_sw_set, flag_sw_clr} = 10'h0;
      {spi_flags, periph_pending, sfr_rd_addr, sfr_wr, delay} = '0;
      repeat (10) step();
      rst_n = 1'b1;
      rd(8'ha8, 8'h00);
      rd(8'hb8, 8'h80);
      rd(8'he6, 8'h00);
      rd(8'hf6, 8'h00);
      rd(8'h55, 8'h00);
      wr(8'he6, 8'hff);
      wr(8'hb8, 8'h7f);
      rd(8'he6, 8'hbd);
      rd(8'hb8, 8'hff);
      wr(8'he6, 8'h00);
      wr(8'hb8, 8'h00);
      wr(8'ha8, 8'h02);
      idle();
      // Set wins over a clear in the same cycle, then a clear alone
      {flag_sw_set, flag_sw_clr} = 8'h44;
      step();
      {flag_sw_set, flag_sw_clr} = 8'h00;
      check("held flags", 16'h4, {12'h0, held_flags});
      flag_sw_clr = 4'h4;
      step();
      flag_sw_clr = 4'h0;
      check("held flags", 16'h0, {12'h0, held_flags});
      // Flag sets with the gate closed, request follows opening it
      timer_a_overflow = 1'b1;
      step();
      timer_a_overflow = 1'b0;
      repeat (6) step();
      check("held flags", 16'h2, {12'h0, held_flags});
      expect_vec(16'h000b);
      wr(8'ha8, 8'h82);
      idle();
      take();
      check("held flags", 16'h0, {12'h0, held_flags});
      ret_irq();
      // Each enable alone; each level source stands until the end of its own turn
      periph_pending[4] = 1'b1;
      {timer_c_low_overflow, timer_c_high_overflow} = 2'(($random(seed) & 1) + 1);
      spi_flags = 4'($random(seed)) | 4'h1;
      for (k = 0; k < 7; k++) begin
         delay = 3'($random(seed));
         wr(8'ha8, 8'h80 | (8'h01 << k));
         idle();
         expect_vec(16'h0003 + 16'(8 * k));
         case (k)
            0: ext_in_a = 1'b0;
            1: timer_a_overflow = 1'b1;
            2: ext_in_b = 1'b0;
            3: timer_b_overflow = 1'b1;
            default: ;
         endcase
         step();
         {timer_a_overflow, timer_b_overflow} = 2'b00;
         take();
         {ext_in_a, ext_in_b} = 2'b11;
         if (k > 3) begin
            expect_vec(16'h0003 + 16'(8 * k));
            ret_irq();
            take();
         end
         case (k)
            4: periph_pending[4] = 1'b0;
            5: {timer_c_low_overflow, timer_c_high_overflow} = 2'b00;
            6: spi_flags = 4'h0;
            default: ;
         endcase
         ret_irq();
      end
      wr(8'hb8, 8'h08);
      wr(8'ha8, 8'h8f);
      idle();
      for (k = 0; k < 4; k++) begin
         expect_vec(seq[k]);
         if (k == 0) flag_sw_set = 4'hf;
         else ret_irq();
         step();
         flag_sw_set = 4'h0;
         take();
         if (k == 0) check("levels", 16'h2, {14'h0, active_levels});
      end
      ret_irq();
      wr(8'hb8, 8'h02);
      wr(8'ha8, 8'h83);
      idle();
      delay = 3'h0;
      expect_vec(16'h0003);
      flag_sw_set = 4'h1;
      step();
      flag_sw_set = 4'h0;
      take();
      expect_vec(16'h000b);
      timer_a_overflow = 1'b1;
      step();
      timer_a_overflow = 1'b0;
      step();
      check("request", 16'h1, {15'h0, irq_req.valid});
      take();
      check("levels", 16'h3, {14'h0, active_levels});
      ret_irq();
      check("levels", 16'h1, {14'h0, active_levels});
      ret_irq();
      // Extended sources; reserved orders never request
      wr(8'he6, 8'hff);
      wr(8'ha8, 8'h80);
      idle();
      expect_vec(16'h003b);
      periph_pending = 15'h6180;
      take();
      expect_vec(16'h0073);
      periph_pending[7] = 1'b0;
      ret_irq();
      take();
      periph_pending = '0;
      // Reset in mid-run drops the level and the registers
      rst_n = 1'b0;
      step();
      check("levels", 16'h0, {14'h0, active_levels});
      rst_n = 1'b1;
      rd(8'he6, 8'h00);
      rd(8'hb8, 8'h80);
      idle();
      conclude();
   end
endmodule
`default_nettype wire
